// >>> core/vc_search_consts.svh
/*
  constants of the connection search front end: register map, field
  positions, reset values, memory regions and search limits.
  assumes a 100 MHz system clock and a 20-bit external sram address.
*/
`ifndef VC_SEARCH_CONSTS_SVH
`define VC_SEARCH_CONSTS_SVH

// ==========================================================
// register map (byte addresses are four times the index)
`define FIELD_A_INDEX 8'h28
`define FIELD_B_INDEX 8'h29
`define FIELD_A_ADDR 8'ha0
`define FIELD_B_ADDR 8'ha4
`define CONFIG_ADDR 8'h00
`define STATUS_ADDR 8'h04
`define DISCARD_ADDR 8'h08

// ==========================================================
// field positions and reset values
`define START_RESET 6'h00
`define CONFIG_RESET 32'h0000_0000
`define CFG_PORT_CODE_LSB 0
`define CFG_PRI_LEN_LSB 8
`define CFG_SEC_LEN_LSB 16
`define CFG_DIVERT_BIT 24

// ==========================================================
// memory layout and search limits
`define PRIMARY_NIBBLE 4'h1
`define TREE_NIBBLE 4'h0
`define RECORD_NIBBLE 4'h2
`define RECORD_KEY_WORD 16'h0002
`define MAX_PORT_BITS 3'h5
`define MAX_PRI_BITS 5'h10
`define MAX_SEC_BITS 4'hb
`define MAX_TREE_DEPTH 6'h27
`define PIPE_OVERHEAD_CLKS 17

`endif

// >>> core/vc_search_pkg.sv
/*
  types of the connection search front end.
  assumes the constants header is included by the design file.
*/
package vc_search_pkg;

  // walk states, gray coded along the normal path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_P_RD = 3'b001,
    ST_P_WT = 3'b011,
    ST_T_RD = 3'b010,
    ST_T_WT = 3'b110,
    ST_V_RD = 3'b111,
    ST_V_WT = 3'b101,
    ST_DONE = 3'b100
  } walk_state_e;

  // outcome of one cell lookup
  typedef enum logic [1:0] {
    VERDICT_MATCH = 2'h0,
    VERDICT_NO_ENTRY = 2'h1,
    VERDICT_MISMATCH = 2'h2,
    VERDICT_TOO_DEEP = 2'h3
  } verdict_e;

endpackage

// >>> core/vc_search_key_lookup.sv
/*
  connection search front end: builds primary and secondary keys from
  each cell's routing word and source port, looks up the primary table,
  walks the binary tree and checks the stored key of the record found.
  assumes an sram whose read data is valid the cycle after the read
  strobe, cells offered by same-clock logic, and an axi4-lite master.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "vc_search_consts.svh"

module vc_search_key_lookup (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  // cell offered for lookup
  input wire logic cell_valid_in,
  input wire logic [4:0] source_port_bits_in,
  input wire logic [63:0] routing_word_in,
  output logic cell_ready_out,
  // lookup result
  output logic result_valid_out,
  output vc_search_pkg::verdict_e result_verdict_out,
  output logic result_divert_out,
  output logic [15:0] result_record_out,
  // external sram read port
  output logic sram_rd_out,
  output logic [19:0] sram_addr_out,
  input wire logic [39:0] sram_rdata_in,
  // axi4-lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import vc_search_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [15:0] low_mask16(input logic [4:0] n);
    low_mask16 = (n >= 5'h10) ? 16'hffff : ((16'h0001 << n) - 16'h0001);
  endfunction

  // map a byte address to a register number, 7 for unmapped
  function automatic logic [2:0] reg_decode(input logic [7:0] a);
    if (a == `CONFIG_ADDR) begin
      reg_decode = 3'h0;
    end else if (a == `STATUS_ADDR) begin
      reg_decode = 3'h1;
    end else if (a == `DISCARD_ADDR) begin
      reg_decode = 3'h2;
    end else if (a == `FIELD_A_ADDR) begin
      reg_decode = 3'h3;
    end else if (a == `FIELD_B_ADDR) begin
      reg_decode = 3'h4;
    end else begin
      reg_decode = 3'h7;
    end
  endfunction

  // ==========================================================
  // registers
  logic [31:0] config_reg;
  logic [5:0] field_a_start_reg;
  logic [5:0] field_b_start_reg;
  logic [15:0] discard_count_reg;
  walk_state_e state_reg, state_next;
  logic [15:0] pkey_reg;
  logic [38:0] skey_reg;
  logic [15:0] record_reg;
  logic [5:0] depth_reg;
  logic divert_latch_reg;
  logic [15:0] sram_ptr_next;
  logic [3:0] sram_nibble_next;

  // ==========================================================
  // key assembly
  wire logic [2:0] port_code_w = config_reg[`CFG_PORT_CODE_LSB +: 3];
  wire logic [4:0] pri_len_w = config_reg[`CFG_PRI_LEN_LSB +: 5];
  wire logic [3:0] sec_len_w = config_reg[`CFG_SEC_LEN_LSB +: 4];
  wire logic divert_en_w = config_reg[`CFG_DIVERT_BIT];
  // codes past five saturate so the key never overflows 16 bits
  wire logic [2:0] lp_w = (port_code_w > `MAX_PORT_BITS) ?
    `MAX_PORT_BITS : port_code_w;
  wire logic [4:0] la_room_w = `MAX_PRI_BITS - {2'h0, lp_w};
  wire logic [4:0] la_w = (pri_len_w > la_room_w) ?
    la_room_w : pri_len_w;
  wire logic [3:0] lb_w = (sec_len_w > `MAX_SEC_BITS) ?
    `MAX_SEC_BITS : sec_len_w;
  wire logic [63:0] rw_a_w = routing_word_in >> field_a_start_reg;
  wire logic [63:0] rw_b_w = routing_word_in >> field_b_start_reg;
  wire logic [15:0] field_a_w = rw_a_w[15:0] & low_mask16(la_w);
  wire logic [15:0] mask_b_w = low_mask16({1'b0, lb_w});
  wire logic [10:0] field_b_w = rw_b_w[10:0] & mask_b_w[10:0];
  wire logic [15:0] port_w = {11'h000, source_port_bits_in} &
    low_mask16({2'h0, lp_w});
  // port bits above field a, forming a 2^(lp+la) index
  wire logic [15:0] pkey_w = (port_w << la_w) | field_a_w;
  // path/channel id always from the header word, never appended bytes
  wire logic [38:0] skey_w = {field_b_w, routing_word_in[31:4]};

  // ==========================================================
  // tree node decode
  wire logic [5:0] node_sel_w = sram_rdata_in[39:34];
  wire logic [63:0] skey_ext_w = {25'h0000000, skey_reg};
  wire logic dec_bit_w = skey_ext_w[node_sel_w];
  wire logic leaf_w = dec_bit_w ? sram_rdata_in[33] : sram_rdata_in[16];
  wire logic [15:0] ptr_w = dec_bit_w ? sram_rdata_in[32:17] :
    sram_rdata_in[15:0];
  wire logic root_null_w = (sram_rdata_in[15:0] == 16'h0000);

  // ==========================================================
  // record key check: unused mask bits widen with uni and vp records
  wire logic flag_w = sram_rdata_in[39];
  wire logic vp_only_w = (sram_rdata_in[15:0] == 16'h0000);
  wire logic [38:0] check_mask_w = {11'h7ff,
    flag_w ? 4'hf : 4'h0, 8'hff,
    vp_only_w ? 16'h0000 : 16'hffff};
  // shared primary bits are checked here in full, never branched on
  wire logic match_w =
    (((sram_rdata_in[38:0] ^ skey_reg) & check_mask_w) == 39'h0);

  // ==========================================================
  // walk sequencer: one read per node, bounded by the key width
  always_comb begin
    state_next = state_reg;
    sram_ptr_next = 16'h0000;
    sram_nibble_next = `TREE_NIBBLE;
    case (state_reg)
      ST_IDLE: begin
        if (cell_valid_in) begin
          state_next = ST_P_RD;
          sram_ptr_next = pkey_w;
          sram_nibble_next = `PRIMARY_NIBBLE;
        end
      end
      ST_P_RD: state_next = ST_P_WT;
      ST_P_WT: begin
        if (root_null_w) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_T_RD;
          sram_ptr_next = sram_rdata_in[15:0];
        end
      end
      ST_T_RD: state_next = ST_T_WT;
      ST_T_WT: begin
        if (leaf_w) begin
          state_next = ST_V_RD;
          sram_ptr_next = ptr_w + `RECORD_KEY_WORD;
          sram_nibble_next = `RECORD_NIBBLE;
        end else if (depth_reg == `MAX_TREE_DEPTH) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_T_RD;
          sram_ptr_next = ptr_w;
        end
      end
      ST_V_RD: state_next = ST_V_WT;
      ST_V_WT: state_next = ST_DONE;
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // sequencer state and sram request
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      sram_rd_out <= 1'b0;
      sram_addr_out <= 20'h00000;
      cell_ready_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      sram_rd_out <= (state_next == ST_P_RD) || (state_next == ST_T_RD) ||
        (state_next == ST_V_RD);
      if (state_next == ST_P_RD || state_next == ST_T_RD ||
          state_next == ST_V_RD) begin
        sram_addr_out <= {sram_nibble_next, sram_ptr_next};
      end
      cell_ready_out <= (state_next == ST_IDLE);
    end
  end

  // keys, depth and record latched per cell
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pkey_reg <= 16'h0000;
      skey_reg <= 39'h0;
      depth_reg <= 6'h00;
      record_reg <= 16'h0000;
      divert_latch_reg <= 1'b0;
    end else if (state_reg == ST_IDLE && cell_valid_in) begin
      pkey_reg <= pkey_w;
      skey_reg <= skey_w;
      depth_reg <= 6'h01; // node count, so the cap stops at node 39
      divert_latch_reg <= divert_en_w;
    end else if (state_reg == ST_T_WT) begin
      depth_reg <= depth_reg + 6'h01;
      record_reg <= ptr_w;
    end
  end

  // result presented for one cycle while in done
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      result_valid_out <= 1'b0;
      result_verdict_out <= VERDICT_NO_ENTRY;
      result_divert_out <= 1'b0;
      result_record_out <= 16'h0000;
      discard_count_reg <= 16'h0000;
    end else begin
      result_valid_out <= (state_next == ST_DONE);
      if (state_reg == ST_P_WT && root_null_w) begin
        result_verdict_out <= VERDICT_NO_ENTRY;
        result_divert_out <= divert_latch_reg;
        discard_count_reg <= discard_count_reg + 16'h0001;
      end else if (state_reg == ST_T_WT && !leaf_w &&
                   depth_reg == `MAX_TREE_DEPTH) begin
        result_verdict_out <= VERDICT_TOO_DEEP;
        result_divert_out <= divert_latch_reg;
        discard_count_reg <= discard_count_reg + 16'h0001;
      end else if (state_reg == ST_V_WT) begin
        result_verdict_out <= match_w ? VERDICT_MATCH : VERDICT_MISMATCH;
        result_divert_out <= !match_w && divert_latch_reg;
        result_record_out <= record_reg;
        if (!match_w) begin
          discard_count_reg <= discard_count_reg + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // axi4-lite slave: address and data taken in either order
  wire logic aw_hs_w = s_axi_awvalid && s_axi_awready;
  wire logic w_hs_w = s_axi_wvalid && s_axi_wready;
  wire logic do_write_w = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  wire logic [2:0] wsel_w = reg_decode(awaddr_reg);
  wire logic [2:0] rsel_w = reg_decode(s_axi_araddr);
  wire logic [31:0] status_w = {8'h00, result_record_out,
    5'h00, state_reg != ST_IDLE, result_verdict_out};
  wire logic [31:0] rmux_w =
    (rsel_w == 3'h0) ? config_reg :
    (rsel_w == 3'h1) ? status_w :
    (rsel_w == 3'h2) ? {16'h0000, discard_count_reg} :
    (rsel_w == 3'h3) ? {26'h0000000, field_a_start_reg} :
    (rsel_w == 3'h4) ? {26'h0000000, field_b_start_reg} : 32'h00000000;

  // write channel handshakes and response
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_hs_w) begin
        s_axi_awready <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs_w) begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write_w) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel_w == 3'h7 || wsel_w == 3'h1 ||
          wsel_w == 3'h2) ? 2'h2 : 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // register writes; 6-bit registers take lane 0 only
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_cfg_lane
      always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
          config_reg[lane*8 +: 8] <= 8'(`CONFIG_RESET >> (lane*8));
        end else if (do_write_w && wsel_w == 3'h0 && wstrb_reg[lane]) begin
          config_reg[lane*8 +: 8] <= wdata_reg[lane*8 +: 8];
        end
      end
    end
  endgenerate

  // field start registers steer the extractors
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      field_a_start_reg <= `START_RESET;
      field_b_start_reg <= `START_RESET;
    end else if (do_write_w && wstrb_reg[0]) begin
      if (wsel_w == 3'h3) begin
        field_a_start_reg <= wdata_reg[5:0];
      end
      if (wsel_w == 3'h4) begin
        field_b_start_reg <= wdata_reg[5:0];
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux_w;
      s_axi_rresp <= (rsel_w == 3'h7) ? 2'h2 : 2'h0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  sequence s_cell_taken;
    state_reg == ST_IDLE && cell_valid_in;
  endsequence

  sequence s_primary_read;
    sram_rd_out && sram_addr_out[19:16] == `PRIMARY_NIBBLE;
  endsequence

  a_primary_index: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    s_cell_taken |=> s_primary_read ##0
      sram_addr_out[15:0] == $past(pkey_w))
    else $error("primary read not at key index");

  a_null_root: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    state_reg == ST_P_WT && root_null_w |=>
      result_valid_out && result_verdict_out == VERDICT_NO_ENTRY)
    else $error("null root did not end the lookup");

  a_branch_addr: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    state_reg == ST_T_WT && !leaf_w && depth_reg != `MAX_TREE_DEPTH |=>
      sram_rd_out && sram_addr_out == {`TREE_NIBBLE, $past(ptr_w)})
    else $error("tree branch read wrong node");

  a_leaf_record: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    state_reg == ST_T_WT && leaf_w |=> sram_rd_out ##0
      sram_addr_out[15:0] == $past(ptr_w) + `RECORD_KEY_WORD ##2
      result_valid_out)
    else $error("leaf did not lead to record check");

  a_key_layout: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    skey_w[27:0] == routing_word_in[31:4] && (skey_w[38:28] & ~mask_b_w[10:0])
      == 11'h000)
    else $error("secondary key layout broken");

  a_primary_width: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    ({16'h0000, pkey_w} >> ({2'h0, lp_w} + la_w)) == 32'h0)
    else $error("primary key wider than its lengths");

  a_verify_result: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    state_reg == ST_V_WT |=> result_valid_out &&
      (result_verdict_out == VERDICT_MATCH) == $past(match_w) &&
      result_divert_out == ($past(!match_w) && divert_latch_reg))
    else $error("record check verdict wrong");

  a_depth_bound: assert property (@(posedge ref_clk_in)
    disable iff (!resetn_in)
    (state_reg == ST_T_WT |-> depth_reg <= `MAX_TREE_DEPTH) and
    (sram_rd_out |=> !sram_rd_out))
    else $error("walk exceeded key width or read twice");

endmodule
`default_nettype wire

// >>> tb/sram_table_model.sv
/*
  behavioural external sram holding primary table, tree nodes, records.
  assumes the lookup block strobes a read for one cycle and samples the
  data in the cycle after.
*/
`timescale 1ns/100ps
`default_nettype none

module sram_table_model (
  // clock
  input wire logic ref_clk_in,
  // read port from the lookup block
  input wire logic rd_in,
  input wire logic [19:0] addr_in,
  output logic [39:0] rdata_out
);
  // ==========================================================
  // storage
  // unwritten words read as zero, so the primary table starts empty
  logic [39:0] mem [bit [19:0]];
  logic [39:0] data_reg = 40'h00_0000_0000;

  // bench loads primary entries, nodes and records by region nibble
  task automatic poke(input logic [19:0] a, input logic [39:0] d);
    mem[a] = d;
  endtask

  // ==========================================================
  // read path
  // data stands one cycle, then toggles so a late sample sees junk
  always @(posedge ref_clk_in) begin
    if (rd_in === 1'b1 && mem.exists(addr_in)) begin
      data_reg <= mem[addr_in];
    end else if (rd_in === 1'b1) begin
      data_reg <= 40'h00_0000_0000;
    end else begin
      data_reg <= ~data_reg;
    end
  end
  assign rdata_out = data_reg;
endmodule
`default_nettype wire

// >>> tb/tb_vc_search_key_lookup.sv
/*
  self-checking bench of the connection search front end.
  assumes the constants header on the include path and the sram model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "vc_search_consts.svh"

module tb_vc_search_key_lookup;
  import vc_search_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  localparam logic [63:0] CELL_NULL = 64'h0000_0a00_0012_3450;
  localparam logic [63:0] CELL_A = 64'h0004_0300_0123_4570;
  localparam logic [63:0] CELL_B = 64'h0004_0300_0123_4560;
  localparam logic [63:0] CELL_C = 64'h0000_0300_0123_4570;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cell_valid_in = 1'b0;
  logic [4:0] source_port_bits_in = 5'h00;
  logic [63:0] routing_word_in = 64'h0;
  logic cell_ready_out, result_valid_out, result_divert_out, sram_rd_out;
  verdict_e result_verdict_out;
  logic [15:0] result_record_out;
  logic [19:0] sram_addr_out;
  logic [39:0] sram_rdata_in;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [19:0] reads [$];
  int n_mismatch = 0;
  int checked = 0;

  // 100 MHz system clock
  always #5 ref_clk_in = ~ref_clk_in;

  vc_search_key_lookup dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .cell_valid_in(cell_valid_in), .source_port_bits_in(source_port_bits_in),
    .routing_word_in(routing_word_in), .cell_ready_out(cell_ready_out),
    .result_valid_out(result_valid_out),
    .result_verdict_out(result_verdict_out),
    .result_divert_out(result_divert_out),
    .result_record_out(result_record_out), .sram_rd_out(sram_rd_out),
    .sram_addr_out(sram_addr_out), .sram_rdata_in(sram_rdata_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  sram_table_model mem_model (.ref_clk_in(ref_clk_in), .rd_in(sram_rd_out),
    .addr_in(sram_addr_out), .rdata_out(sram_rdata_in));

  // log every sram address the walk strobes
  always @(posedge ref_clk_in) begin
    if (sram_rd_out === 1'b1) begin
      reads.push_back(sram_addr_out);
    end
  end

  // ==========================================================
  // shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // a stuck handshake ends the run instead of hanging
  task automatic give_up(input string msg);
    check(1'b0, msg);
    print_verdict();
  endtask

  // secondary key for field b at bit 48, three bits long
  function automatic logic [38:0] skey(input logic [63:0] rw);
    return {8'h00, rw[50:48], rw[31:4]};
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] resp);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge ref_clk_in);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        check(s_axi_bresp === resp, "write response");
      end
    end
    if (!done) give_up("write timeout");
    // one idle edge so bready is not lowered and raised in one step
    @(posedge ref_clk_in);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] resp);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge ref_clk_in);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata === d && s_axi_rresp === resp, "read data");
      end
    end
    if (!done) give_up("read timeout");
    @(posedge ref_clk_in);
  endtask

  // offers one cell, waits for its verdict, judges reads and result
  task automatic run_cell(input logic [4:0] port, input logic [63:0] rw,
      input verdict_e v, input logic [15:0] rec, input logic div,
      input int nreads, input logic [19:0] first, input logic [19:0] last);
    int n;
    reads.delete();
    for (n = 0; n < 50 && cell_ready_out !== 1'b1; n++) begin
      @(posedge ref_clk_in);
    end
    if (n >= 50) give_up("cell never taken");
    cell_valid_in <= 1'b1;
    source_port_bits_in <= port;
    routing_word_in <= rw;
    @(posedge ref_clk_in);
    cell_valid_in <= 1'b0;
    for (n = 1; n <= 100 && result_valid_out !== 1'b1; n++) begin
      @(posedge ref_clk_in);
    end
    if (n > 100) give_up("no result");
    // a capped walk has no tree depth to bound it
    check(v == VERDICT_TOO_DEEP || n <= 17 + nreads, "cell time");
    check(result_verdict_out === v, "verdict");
    check(result_divert_out === div, "divert flag");
    check(v == VERDICT_NO_ENTRY || result_record_out === rec, "record");
    check(reads.size() == nreads, "read count");
    check(reads[0] === first, "primary index");
    check(reads[$] === last, "last address");
  endtask

  // ==========================================================
  // scenarios
  task automatic test_registers();
    axi_read(`CONFIG_ADDR, 32'h0, 2'h0);
    axi_read(`FIELD_A_ADDR, 32'h0, 2'h0);
    axi_write(`FIELD_A_ADDR, 32'h28, 2'h0);
    axi_write(`FIELD_B_ADDR, 32'h30, 2'h0);
    axi_read(`FIELD_A_ADDR, 32'h28, 2'h0);
    axi_read(`FIELD_B_ADDR, 32'h30, 2'h0);
    axi_write(`STATUS_ADDR, 32'hff, 2'h2);
    axi_read(8'h0c, 32'h0, 2'h2);
    axi_write(`CONFIG_ADDR, 32'h0003_0402, 2'h0);
  endtask

  // port 01 above field a 1010 gives index 0x1a, left empty
  task automatic test_null_root();
    run_cell(5'h01, CELL_NULL, VERDICT_NO_ENTRY, 16'h0, 1'b0, 1,
      20'h1001a, 20'h1001a);
  endtask

  // two-level tree: bit 0 then key bit 30 inside field b
  task automatic test_tree_match();
    mem_model.poke(20'h10023, 40'h00_0000_0100);
    mem_model.poke(20'h00100, {6'd0, 1'b0, 16'h0200, 1'b1, 16'h0300});
    mem_model.poke(20'h00200, {6'd30, 1'b1, 16'h0400, 1'b1, 16'h0500});
    mem_model.poke(20'h20402, {1'b1, skey(CELL_A)});
    mem_model.poke(20'h20302, 40'h80_0000_0001);
    mem_model.poke(20'h20502, {1'b0, 11'h000, 28'hf12_0000});
    run_cell(5'h02, CELL_A, VERDICT_MATCH, 16'h0400, 1'b0, 4,
      20'h10023, 20'h20402);
  endtask

  // wrong stored key with divert on; count covers both discards
  task automatic test_mismatch_divert();
    axi_write(`CONFIG_ADDR, 32'h0103_0402, 2'h0);
    run_cell(5'h02, CELL_B, VERDICT_MISMATCH, 16'h0300, 1'b1, 3,
      20'h10023, 20'h20302);
    axi_read(`DISCARD_ADDR, 32'h2, 2'h0);
  endtask

  // stored flag zero and empty channel id mask the differing bits
  task automatic test_uni_vpc();
    run_cell(5'h02, CELL_C, VERDICT_MATCH, 16'h0500, 1'b0, 4,
      20'h10023, 20'h20502);
  endtask

  // self-looping node runs the walk into the 39-node cap
  task automatic test_too_deep();
    mem_model.poke(20'h10033, 40'h00_0000_0600);
    mem_model.poke(20'h00600, {6'h00, 1'b0, 16'h0600, 1'b0, 16'h0600});
    run_cell(5'h03, CELL_A, VERDICT_TOO_DEEP, 16'h0500, 1'b1, 40,
      20'h10033, 20'h00600);
    axi_read(`DISCARD_ADDR, 32'h3, 2'h0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    test_registers();
    test_null_root();
    test_tree_match();
    test_mismatch_divert();
    test_uni_vpc();
    test_too_deep();
    print_verdict();
  end
endmodule
`default_nettype wire
